/* common/tpc_pkg.sv */
package tpc_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [11:0] TPC_IDX_COUNT_LOW  = 12'hfd2;
  localparam logic [11:0] TPC_IDX_COUNT_HIGH = 12'hfd3;
  localparam logic [11:0] TPC_IDX_CTL_ZERO   = 12'hfd4;
  localparam logic [11:0] TPC_IDX_CTL_ONE    = 12'hfd5;
  localparam logic [11:0] TPC_IDX_IRQ        = 12'hfd6;

  // Field positions in the interrupt register
  localparam int unsigned TPC_IRQ_FLAG_BIT   = 0;
  localparam int unsigned TPC_IRQ_ENABLE_BIT = 1;

  // Values after reset, and the wrap value of the wide count
  localparam logic [7:0]  TPC_CTL_ZERO_RST   = 8'h00;
  localparam logic [7:0]  TPC_CTL_ONE_RST    = 8'h00;
  localparam logic [7:0]  TPC_COUNT_HIGH_RST = 8'h00;
  localparam logic [15:0] TPC_COUNT_RST      = 16'h0000;
  localparam logic [15:0] TPC_COUNT_WRAP     = 16'hffff;

  // Bus answers
  localparam logic [1:0]  TPC_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  TPC_RESP_SLVERR    = 2'h2;

  // Counter clock sources
  typedef enum logic [2:0] {
    TPC_SRC_PIN       = 3'b000,
    TPC_SRC_PIN_INV   = 3'b001,
    TPC_SRC_INSTR     = 3'b010,
    TPC_SRC_HIGH_OSC  = 3'b011,
    TPC_SRC_LOW_OSC   = 3'b100,
    TPC_SRC_SEC_OSC   = 3'b101,
    TPC_SRC_MID_OSC   = 3'b110,
    TPC_SRC_LOGIC_C1  = 3'b111
  } tpc_src_e;

  // First control register layout
  typedef struct packed {
    logic       module_enable;
    logic       unused6;
    logic       output_status_bit;
    logic       wide_mode_select;
    logic [3:0] postscale_field;
  } tpc_ctl_zero_s;

  // Second control register layout
  typedef struct packed {
    tpc_src_e   clock_source_field;
    logic       async_select;
    logic [3:0] prescale_field;
  } tpc_ctl_one_s;

  // Raw clock source levels from outside the core clock domain
  typedef struct packed {
    logic logic_cell1_output;
    logic mid_internal_osc;
    logic secondary_osc;
    logic low_internal_osc;
    logic high_internal_osc;
    logic clock_pin;
  } tpc_osc_s;

endpackage

/* src/tpc_top.sv */
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module tpc_top (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_awaddr,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  output logic [1:0]            s_axi_bresp,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  input  wire logic [31:0]      s_axi_araddr,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  input  wire tpc_pkg::tpc_osc_s osc_in,
  input  wire logic             instr_tick,
  input  wire logic             sleep_mode,
  output logic                  timer_output,
  output logic                  timer_irq,
  output logic                  wake_req
);

  // Word index of a byte address, with a hit flag for the map
  function automatic logic [12:0] decode(input logic [31:0] addr);
    logic [11:0] idx;
    logic        hit;
    idx = addr[13:2];
    hit = (addr[31:14] == 18'h00000) &&
          (idx >= tpc_pkg::TPC_IDX_COUNT_LOW) &&
          (idx <= tpc_pkg::TPC_IDX_IRQ);
    return {hit, idx};
  endfunction

  // Low-bit mask of a power-of-two prescale ratio
  function automatic logic [14:0] pre_mask(input logic [3:0] ps);
    logic [15:0] full;
    full = (16'h0001 << ps) - 16'h0001;
    return full[14:0];
  endfunction

  // Write channel state
  logic        aw_held_q;
  logic [12:0] aw_dec_q;
  logic        w_held_q;
  logic [7:0]  wdata_q;
  logic        wstrb0_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  // Read channel state
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  // Control and counter state
  tpc_pkg::tpc_ctl_zero_s ctl0_q;
  tpc_pkg::tpc_ctl_one_s  ctl1_q;
  logic [7:0]  count_high_q;
  logic [7:0]  shadow_q;
  logic [15:0] count_q;
  logic [14:0] pre_cnt_q;
  logic        pend_q;
  logic [3:0]  post_cnt_q;
  logic        out_q;
  logic        flag_q;
  logic        irq_en_q;
  // Source sampling
  tpc_pkg::tpc_osc_s sync1_q;
  tpc_pkg::tpc_osc_s sync2_q;
  logic        lvl_q;
  logic        lvl_d;

  logic        wr_fire;
  logic        wr_en;
  logic [11:0] wr_idx;
  logic        wr_low;
  logic        wr_high;
  logic        wr_ctl0;
  logic        wr_ctl1;
  logic        wr_irq;
  logic        clr_scalers;
  logic        rd_fire;
  logic [12:0] rd_dec;
  logic        rd_low;
  logic        src_edge;
  logic        pre_tick;
  logic        adv;
  logic        evt;
  logic        toggle;

  // Bus handshakes; new requests wait while a response is pending
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Write commits once both halves are held
  assign wr_fire     = aw_held_q && w_held_q && !bvalid_q;
  assign wr_en       = wr_fire && aw_dec_q[12] && wstrb0_q;
  assign wr_idx      = aw_dec_q[11:0];
  assign wr_low      = wr_en && (wr_idx == tpc_pkg::TPC_IDX_COUNT_LOW);
  assign wr_high     = wr_en && (wr_idx == tpc_pkg::TPC_IDX_COUNT_HIGH);
  assign wr_ctl0     = wr_en && (wr_idx == tpc_pkg::TPC_IDX_CTL_ZERO);
  assign wr_ctl1     = wr_en && (wr_idx == tpc_pkg::TPC_IDX_CTL_ONE);
  assign wr_irq      = wr_en && (wr_idx == tpc_pkg::TPC_IDX_IRQ);
  assign clr_scalers = wr_low || wr_ctl0 || wr_ctl1;

  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign rd_dec  = decode(s_axi_araddr);
  assign rd_low  = rd_fire && rd_dec[12] &&
                   (rd_dec[11:0] == tpc_pkg::TPC_IDX_COUNT_LOW);

  // Write address capture
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_held_q <= 1'b0;
      aw_dec_q  <= 13'h0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_dec_q  <= decode(s_axi_awaddr);
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  // Write data capture; only the low byte lane carries a register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      w_held_q <= 1'b0;
      wdata_q  <= 8'h00;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata[7:0];
      wstrb0_q <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer with a slave error
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= tpc_pkg::TPC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= aw_dec_q[12] ? tpc_pkg::TPC_RESP_OKAY
                               : tpc_pkg::TPC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read data path; reserved bits and unmapped words read zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= tpc_pkg::TPC_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_dec[12] ? tpc_pkg::TPC_RESP_OKAY
                             : tpc_pkg::TPC_RESP_SLVERR;
      rdata_q  <= 32'h00000000;
      if (rd_dec[12]) begin
        unique case (rd_dec[11:0])
          tpc_pkg::TPC_IDX_COUNT_LOW:  rdata_q[7:0] <= count_q[7:0];
          tpc_pkg::TPC_IDX_COUNT_HIGH: rdata_q[7:0] <= count_high_q;
          tpc_pkg::TPC_IDX_CTL_ZERO:   rdata_q[7:0] <= ctl0_q;
          tpc_pkg::TPC_IDX_CTL_ONE:    rdata_q[7:0] <= ctl1_q;
          default:                     rdata_q[1:0] <= {irq_en_q, flag_q};
        endcase
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Control registers; the status bit is not writable
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctl0_q <= tpc_pkg::TPC_CTL_ZERO_RST;
      ctl1_q <= tpc_pkg::TPC_CTL_ONE_RST;
    end else begin
      if (wr_ctl0) begin
        ctl0_q.module_enable    <= wdata_q[7];
        ctl0_q.wide_mode_select <= wdata_q[4];
        ctl0_q.postscale_field  <= wdata_q[3:0];
      end
      if (wr_ctl1) begin
        ctl1_q <= wdata_q;
      end
      ctl0_q.output_status_bit <= out_q;
    end
  end

  // Period or high-byte buffer; software write beats the read latch
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count_high_q <= tpc_pkg::TPC_COUNT_HIGH_RST;
    end else if (wr_high) begin
      count_high_q <= wdata_q;
    end else if (rd_low && ctl0_q.wide_mode_select) begin
      count_high_q <= count_q[15:8];
    end
  end

  // Two-stage synchroniser on every outside clock source
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= osc_in;
      sync2_q <= sync1_q;
    end
  end

  // Source select from the second stage only
  always_comb begin
    unique case (ctl1_q.clock_source_field)
      tpc_pkg::TPC_SRC_PIN:      lvl_d = sync2_q.clock_pin;
      tpc_pkg::TPC_SRC_PIN_INV:  lvl_d = !sync2_q.clock_pin;
      tpc_pkg::TPC_SRC_INSTR:    lvl_d = 1'b0;
      tpc_pkg::TPC_SRC_HIGH_OSC: lvl_d = sync2_q.high_internal_osc;
      tpc_pkg::TPC_SRC_LOW_OSC:  lvl_d = sync2_q.low_internal_osc;
      tpc_pkg::TPC_SRC_SEC_OSC:  lvl_d = sync2_q.secondary_osc;
      tpc_pkg::TPC_SRC_MID_OSC:  lvl_d = sync2_q.mid_internal_osc;
      tpc_pkg::TPC_SRC_LOGIC_C1: lvl_d = sync2_q.logic_cell1_output;
    endcase
  end

  // Previous level for rising-edge detection
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lvl_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
    end
  end

  // Instruction clock source is already a one-cycle tick
  assign src_edge = (ctl1_q.clock_source_field == tpc_pkg::TPC_SRC_INSTR)
                    ? instr_tick : (lvl_d && !lvl_q);

  // Prescaler fires when the low bits of its count are all ones
  assign pre_tick = ctl0_q.module_enable && src_edge && !clr_scalers &&
                    ((pre_cnt_q & pre_mask(ctl1_q.prescale_field)) ==
                     pre_mask(ctl1_q.prescale_field));

  // Prescaler count, invisible to software
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pre_cnt_q <= 15'h0000;
    end else if (clr_scalers) begin
      pre_cnt_q <= 15'h0000;
    end else if (pre_tick) begin
      pre_cnt_q <= 15'h0000;
    end else if (ctl0_q.module_enable && src_edge) begin
      pre_cnt_q <= pre_cnt_q + 15'h0001;
    end
  end

  // Sync mode holds a prescaled edge until the next instruction tick
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= 1'b0;
    end else if (clr_scalers || ctl1_q.async_select) begin
      pend_q <= 1'b0;
    end else if (adv) begin
      pend_q <= 1'b0;
    end else if (pre_tick) begin
      pend_q <= 1'b1;
    end
  end

  // Sync advance is capped at the instruction rate and stops in sleep
  assign adv = ctl0_q.module_enable && !clr_scalers &&
               (ctl1_q.async_select ? pre_tick
                : ((pend_q || pre_tick) && instr_tick && !sleep_mode));

  // Match in 8-bit width, wrap in 16-bit width
  assign evt = adv && (ctl0_q.wide_mode_select
               ? (count_q == tpc_pkg::TPC_COUNT_WRAP)
               : (count_q[7:0] == shadow_q));

  // Counter; a software write to the low byte takes precedence
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= tpc_pkg::TPC_COUNT_RST;
    end else if (wr_low) begin
      count_q[7:0] <= wdata_q;
      if (ctl0_q.wide_mode_select) begin
        count_q[15:8] <= count_high_q;
      end
    end else if (adv) begin
      if (ctl0_q.wide_mode_select) begin
        count_q <= count_q + 16'h0001;
      end else if (evt) begin
        count_q[7:0] <= 8'h00;
      end else begin
        count_q[7:0] <= count_q[7:0] + 8'h01;
      end
    end
  end

  // Period shadow; reloaded only at a match so a new period waits
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      shadow_q <= tpc_pkg::TPC_COUNT_HIGH_RST;
    end else if (evt && !ctl0_q.wide_mode_select) begin
      shadow_q <= count_high_q;
    end
  end

  // Postscaler passes every (field + 1)-th event
  assign toggle = evt && (post_cnt_q == ctl0_q.postscale_field);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      post_cnt_q <= 4'h0;
    end else if (clr_scalers) begin
      post_cnt_q <= 4'h0;
    end else if (toggle) begin
      post_cnt_q <= 4'h0;
    end else if (evt) begin
      post_cnt_q <= post_cnt_q + 4'h1;
    end
  end

  // Output level toggles once per postscaled event
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      out_q <= 1'b0;
    end else if (toggle) begin
      out_q <= !out_q;
    end
  end

  // Sticky flag; a new toggle beats a clear in the same cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else if (toggle) begin
      flag_q <= 1'b1;
    end else if (wr_irq && wdata_q[tpc_pkg::TPC_IRQ_FLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  // Interrupt enable
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_en_q <= 1'b0;
    end else if (wr_irq) begin
      irq_en_q <= wdata_q[tpc_pkg::TPC_IRQ_ENABLE_BIT];
    end
  end

  // Outputs to pin routing, interrupt controller and power control
  assign timer_output = out_q;
  assign timer_irq    = flag_q && irq_en_q;
  assign wake_req     = sleep_mode && ctl1_q.async_select && timer_irq;

endmodule

/* verification/tpc_sva.sv */
`timescale 1ns/1ps
module tpc_sva (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        sleep_mode,
  input wire logic        timer_irq,
  input wire logic        wake_req
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Both write channels handed over at one edge
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Response offered and not yet accepted
  sequence b_waiting;
    s_axi_bvalid && !s_axi_bready;
  endsequence

  wr_answer_a: assert property (aw_w_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  b_hold_a: assert property (b_waiting |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  ar_block_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  byte_wide_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  wake_cause_a: assert property (wake_req |-> sleep_mode && timer_irq)
    else $error("wake without sleep and interrupt");
endmodule

bind tpc_top tpc_sva u_sva (.core_clk(core_clk), .rstn(rstn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .sleep_mode(sleep_mode), .timer_irq(timer_irq), .wake_req(wake_req));

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam logic [11:0] LOW  = tpc_pkg::TPC_IDX_COUNT_LOW;
  localparam logic [11:0] HIGH = tpc_pkg::TPC_IDX_COUNT_HIGH;
  localparam logic [11:0] CTL0 = tpc_pkg::TPC_IDX_CTL_ZERO;
  localparam logic [11:0] CTL1 = tpc_pkg::TPC_IDX_CTL_ONE;
  localparam logic [11:0] IRQ  = tpc_pkg::TPC_IDX_IRQ;
  localparam logic [1:0]  OK   = tpc_pkg::TPC_RESP_OKAY;

  logic              core_clk, rstn, instr_tick, sleep_mode;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready, timer_output, timer_irq, wake_req;
  logic [31:0]       s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  tpc_pkg::tpc_osc_s osc_in;
  int                fail_count, check_count;

  tpc_top DUT (.core_clk(core_clk), .rstn(rstn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .osc_in(osc_in), .instr_tick(instr_tick),
    .sleep_mode(sleep_mode), .timer_output(timer_output),
    .timer_irq(timer_irq), .wake_req(wake_req));

  // 200 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Instruction tick every second cycle keeps expected periods even
  always @(posedge core_clk) instr_tick <= ~instr_tick;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge core_clk);
    s_axi_awaddr <= {18'h0, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge core_clk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rd(input logic [11:0] idx, output logic [7:0] d,
                    input logic [1:0] er);
    @(posedge core_clk);
    s_axi_araddr <= {18'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata[7:0];
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  task automatic rdc(input logic [11:0] idx, input logic [7:0] e);
    logic [7:0] d;
    rd(idx, d, OK);
    chk(32'(d), 32'(e));
  endtask

  // Cycles until the timer output next changes, bounded
  task automatic tog(output int n);
    logic o;
    o = timer_output;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (timer_output === o && n < 4000);
    chk(32'(n < 4000), 32'h1);
  endtask

  // Toggle spacing: two cycles a tick, period three gives four advances
  task automatic meas(input logic [3:0] ps, input logic [3:0] os);
    int n;
    wr(CTL1, {3'b010, 1'b1, ps}, OK);
    wr(CTL0, {4'h8, os}, OK);
    tog(n);
    tog(n);
    tog(n);
    chk(32'(n), 32'(8 * (1 << ps) * (int'(os) + 1)));
  endtask

  task automatic sc_reset;
    logic [7:0] d;
    rdc(CTL0, 8'h00);
    rdc(CTL1, 8'h00);
    rdc(HIGH, 8'h00);
    rdc(IRQ, 8'h00);
    rd(12'hfd7, d, tpc_pkg::TPC_RESP_SLVERR);
    chk(32'(d), 32'h0);
    wr(12'hfd7, 8'h55, tpc_pkg::TPC_RESP_SLVERR);
    wr(CTL0, 8'h20, OK);
    rdc(CTL0, 8'h00);
  endtask

  task automatic sc_period;
    logic [7:0] d, mx;
    mx = 0;
    wr(HIGH, 8'h03, OK);
    wr(CTL1, 8'h50, OK);
    wr(CTL0, 8'h80, OK);
    // Reads three cycles apart, coprime with the eight-cycle period,
    // so every phase of the count gets sampled
    for (int i = 0; i < 16; i++) begin
      rd(LOW, d, OK);
      if (d > mx) mx = d;
    end
    chk(32'(mx), 32'h3);
    meas(4'h0, 4'h0);
    meas(4'h0, 4'h1);
    meas(4'h1, 4'h0);
    meas(4'h2, 4'h3);
    meas(4'h0, 4'hf);
  endtask

  task automatic flip(input int k);
    repeat (k) begin
      osc_in.clock_pin <= ~osc_in.clock_pin;
      repeat (8) @(posedge core_clk);
    end
  endtask

  // Settle the new source before clearing, since a switch can show an edge
  task automatic src(input logic [7:0] v);
    wr(CTL1, v, OK);
    repeat (8) @(posedge core_clk);
    wr(LOW, 8'h00, OK);
  endtask

  task automatic sc_pin;
    src(8'h30);
    flip(3);
    rdc(LOW, 8'h01);
    src(8'h10);
    flip(4);
    rdc(LOW, 8'h02);
  endtask

  task automatic sc_wide;
    logic [7:0] d;
    int n;
    wr(CTL1, 8'h50, OK);
    // Wide counts are loaded only while the module is stopped
    wr(CTL0, 8'h10, OK);
    wr(HIGH, 8'hff, OK);
    wr(LOW, 8'hf0, OK);
    wr(HIGH, 8'h12, OK);
    wr(CTL0, 8'h90, OK);
    rd(LOW, d, OK);
    chk(32'(d >= 8'hf0), 32'h1);
    rdc(HIGH, 8'hff);
    tog(n);
    rd(LOW, d, OK);
    chk(32'(d < 8'h10), 32'h1);
    rdc(HIGH, 8'h00);
    rd(CTL0, d, OK);
    chk(32'(d[5]), 32'(timer_output));
    wr(CTL0, 8'h10, OK);
    wr(HIGH, 8'h34, OK);
    wr(LOW, 8'h80, OK);
    rd(LOW, d, OK);
    chk(32'(d), 32'h80);
    rdc(HIGH, 8'h34);
  endtask

  task automatic sc_sleep;
    logic [7:0] a, b;
    int n;
    wr(CTL0, 8'h80, OK);
    wr(CTL1, 8'h40, OK);
    sleep_mode <= 1'b1;
    rd(LOW, a, OK);
    repeat (20) @(posedge core_clk);
    rd(LOW, b, OK);
    chk(32'(b), 32'(a));
    wr(CTL1, 8'h50, OK);
    rd(LOW, a, OK);
    repeat (6) @(posedge core_clk);
    rd(LOW, b, OK);
    chk(32'(b !== a), 32'h1);
    wr(IRQ, 8'h02, OK);
    tog(n);
    repeat (2) @(posedge core_clk);
    chk(32'(timer_irq), 32'h1);
    chk(32'(wake_req), 32'h1);
    sleep_mode <= 1'b0;
    // Nonzero period first, so a frozen count differs from a stuck one
    wr(HIGH, 8'hff, OK);
    wr(CTL0, 8'h00, OK);
    rd(LOW, a, OK);
    repeat (20) @(posedge core_clk);
    rd(LOW, b, OK);
    chk(32'(b), 32'(a));
    chk(32'(timer_irq), 32'h1);
    wr(IRQ, 8'h03, OK);
    chk(32'(timer_irq), 32'h0);
    rdc(IRQ, 8'h02);
  endtask

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole sequence needs under two thousand cycles; this is a hang guard
  initial begin
    repeat (50000) @(posedge core_clk);
    fail_count++;
    finish_test;
  end

  initial begin
    fail_count = 0;
    check_count = 0;
    rstn = 1'b0;
    instr_tick = 1'b0;
    sleep_mode = 1'b0;
    osc_in = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    sc_reset;
    sc_period;
    sc_pin;
    sc_wide;
    sc_sleep;
    finish_test;
  end
endmodule
